// ---- design/sli_params.svh ----
// Constants of the status LED indicator: offsets, fields, timing
`ifndef SLI_PARAMS_SVH
`define SLI_PARAMS_SVH
// Register byte offsets
`define SLI_CTRL_OFS 12'h000
`define SLI_STAT_OFS 12'h004
`define SLI_INT_ST_OFS 12'h008
`define SLI_INT_MSK_OFS 12'h00c
// Control fields
`define SLI_CTRL_LOSSLESS 0
`define SLI_CTRL_RST 1'h0
// Interrupt event bits
`define SLI_EV_BLOCK 0
`define SLI_EV_DEVERR 1
`define SLI_EV_GWFAULT 2
`define SLI_EV_COMLOSS 3
`define SLI_EV_W 4
// Flash timing: half period in ms, clock in kHz
`define SLI_FLASH_HALF_MS 250
`define SLI_CLK_KHZ 250000
// Half periods a gateway start phase may last
`define SLI_STUCK_TICKS 8'h14
// Irregular flash pattern, one bit per half period
`define SLI_IRREG_PAT 8'h5b
`endif

// ---- design/sli_pkg.sv ----
// Types of the status LED indicator
package sli_pkg;
   // One indicator, three colours
   typedef struct packed {
      logic red;
      logic yel;
      logic grn;
   } sli_led_t;
   // All front-panel indicators
   typedef struct packed {
      sli_led_t proc;
      sli_led_t dev;
      sli_led_t eth;
      sli_led_t gwSys;
      sli_led_t gwCom;
   } sli_leds_t;
   // Process and device status flags
   typedef struct packed {
      logic initBusy;
      logic alarm;
      logic procStarted;
      logic resultOk;
      logic resultNok;
      logic nvmErr;
      logic calErr;
      logic scaleErr;
      logic cardErr;
      logic busErr;
      logic [1:0] transdErr;
      logic [1:0] adcOvfl;
      logic [1:0] grossOvfl;
   } sli_stat_t;
   // Ethernet and gateway status flags
   typedef struct packed {
      logic linkUp;
      logic link100;
      logic linkAct;
      logic gwPowerOk;
      logic fwRunning;
      logic bootCopy;
      logic noConfig;
      logic stackErr;
      logic configured;
      logic commUp;
      logic slaveLost;
      logic slaveDisc;
   } sli_link_t;
   // Gateway system indicator states
   typedef enum logic [4:0] {
      GW_OFF = 5'h01,
      GW_START = 5'h02,
      GW_BOOT = 5'h04,
      GW_RUN = 5'h08,
      GW_FAULT = 5'h10
   } sli_gw_state_t;
   // Whole module state
   typedef struct packed {
      sli_gw_state_t gw;
      logic [31:0] flashCnt;
      logic flashPh;
      logic [2:0] irrPh;
      logic [7:0] stuckCnt;
      logic lossless;
      logic [3:0] intSt;
      logic [3:0] intMask;
      logic blocked;
      logic [3:0] evPrev;
      logic [31:0] prdata;
      sli_leds_t leds;
   } sli_state_t;
endpackage

// ---- design/status_led_indicator.sv ----
// Front-panel status LED indicator with APB registers
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sli_params.svh"

module status_led_indicator
   import sli_pkg::*;
#(
   // Half flash period in cycles, shorten for simulation
   parameter int FLASH_HALF_CYC = `SLI_FLASH_HALF_MS * `SLI_CLK_KHZ
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire sli_stat_t stat,
   input wire sli_link_t link,
   input wire logic procDoneIn,
   input wire logic storeFail,
   input wire logic storeOk,
   output logic procFinished,
   output logic startAllow,
   output var sli_leds_t leds,
   output logic irq
);

   // Mapped register check, used by the error path only
   function automatic logic addrHit(input logic [11:0] a);
      addrHit = (a == `SLI_CTRL_OFS) || (a == `SLI_STAT_OFS) ||
         (a == `SLI_INT_ST_OFS) || (a == `SLI_INT_MSK_OFS);
   endfunction

   sli_state_t st_ff; // Registered state
   sli_state_t nxt_st; // Next state
   logic tick; // End of a flash half period
   logic steadyErr; // Device errors with steady red
   logic flashErr; // Channel errors with flashing red
   logic comLoss; // Any slave communication problem
   logic [`SLI_EV_W-1:0] evNow; // Event levels this cycle
   logic [`SLI_EV_W-1:0] evRise; // Event onsets
   logic wrAcc; // APB write access phase
   logic irrOn; // Irregular pattern bit

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addrHit(paddr);
   assign prdata = st_ff.prdata;
   assign leds = st_ff.leds;
   // Level interrupt while an unmasked sticky bit is set
   assign irq = |(st_ff.intSt & st_ff.intMask);
   // Blocked backup withholds finish and start
   assign procFinished = procDoneIn && !st_ff.blocked;
   assign startAllow = !st_ff.blocked && !stat.initBusy;

   // Event condition decode
   always_comb begin
      tick = (st_ff.flashCnt == 32'(FLASH_HALF_CYC - 1));
      steadyErr = stat.nvmErr || stat.calErr || stat.scaleErr ||
         stat.cardErr || stat.busErr;
      flashErr = |(stat.transdErr | stat.adcOvfl | stat.grossOvfl);
      comLoss = link.slaveLost || link.slaveDisc;
      evNow = '0;
      evNow[`SLI_EV_BLOCK] = st_ff.blocked;
      evNow[`SLI_EV_DEVERR] = steadyErr || flashErr;
      evNow[`SLI_EV_GWFAULT] = (st_ff.gw == GW_FAULT);
      evNow[`SLI_EV_COMLOSS] = comLoss;
      evRise = evNow & ~st_ff.evPrev;
      wrAcc = psel && penable && pwrite;
      // Only the bit under the phase is wanted; the cast cuts the rest on purpose
      irrOn = 1'(`SLI_IRREG_PAT >> st_ff.irrPh);
   end

   // Next-state logic
   always_comb begin
      nxt_st = st_ff;
      // Free-running flash base; one toggle per half period
      if (tick) begin
         nxt_st.flashCnt = '0;
         nxt_st.flashPh = !st_ff.flashPh;
         nxt_st.irrPh = st_ff.irrPh + 3'h1;
      end else begin
         nxt_st.flashCnt = st_ff.flashCnt + 32'h1;
      end

      // Gateway system state
      nxt_st.stuckCnt = '0;
      unique case (st_ff.gw)
         GW_OFF: begin
            if (link.gwPowerOk) begin
               nxt_st.gw = GW_START;
            end
         end
         GW_START: begin
            // Yellow may stand only a bounded time
            nxt_st.stuckCnt = st_ff.stuckCnt + {7'h0, tick};
            if (!link.gwPowerOk) begin
               nxt_st.gw = GW_OFF;
            end else if (link.fwRunning) begin
               nxt_st.gw = GW_RUN;
            end else if (link.bootCopy) begin
               nxt_st.gw = GW_BOOT;
               nxt_st.stuckCnt = '0;
            end else if (tick && st_ff.stuckCnt == `SLI_STUCK_TICKS) begin
               nxt_st.gw = GW_FAULT;
            end
         end
         GW_BOOT: begin
            // Endless boot copy is also a fault
            nxt_st.stuckCnt = st_ff.stuckCnt + {7'h0, tick};
            if (!link.gwPowerOk) begin
               nxt_st.gw = GW_OFF;
            end else if (link.fwRunning) begin
               nxt_st.gw = GW_RUN;
            end else if (tick && st_ff.stuckCnt == `SLI_STUCK_TICKS) begin
               nxt_st.gw = GW_FAULT;
            end
         end
         GW_RUN: begin
            if (!link.gwPowerOk) begin
               nxt_st.gw = GW_OFF;
            end else if (!link.fwRunning) begin
               nxt_st.gw = GW_START;
            end
         end
         GW_FAULT: begin
            // Fault holds until the supply goes away
            if (!link.gwPowerOk) begin
               nxt_st.gw = GW_OFF;
            end
         end
         default: begin
            nxt_st.gw = GW_OFF;
         end
      endcase

      // Backup block: set by failure, freed by a later good store
      if (st_ff.lossless && storeFail) begin
         nxt_st.blocked = 1'b1;
      end else if (storeOk || !st_ff.lossless) begin
         nxt_st.blocked = 1'b0;
      end

      // Process indicator, highest priority first
      nxt_st.leds.proc = '0;
      if (stat.initBusy) begin
         nxt_st.leds.proc.red = 1'b1;
      end else if (stat.alarm) begin
         nxt_st.leds.proc.red = st_ff.flashPh;
      end else if (stat.resultNok) begin
         nxt_st.leds.proc.red = 1'b1;
      end else if (stat.resultOk) begin
         nxt_st.leds.proc.grn = 1'b1;
      end else if (stat.procStarted) begin
         nxt_st.leds.proc.yel = st_ff.flashPh;
      end

      // Device status indicator; steady errors outrank flashing ones
      nxt_st.leds.dev = '0;
      if (stat.initBusy) begin
         nxt_st.leds.dev.red = 1'b1;
      end else if (steadyErr) begin
         nxt_st.leds.dev.red = 1'b1;
      end else if (flashErr) begin
         nxt_st.leds.dev.red = st_ff.flashPh;
      end

      // Ethernet port: green marks the fast rate only
      nxt_st.leds.eth = '0;
      if (link.linkUp) begin
         nxt_st.leds.eth.grn = link.link100;
         // Yellow flickers with traffic, else steady
         nxt_st.leds.eth.yel = link.linkAct ? st_ff.flashPh : 1'b1;
      end

      // Gateway system indicator from its state
      nxt_st.leds.gwSys = '0;
      unique case (nxt_st.gw)
         GW_START: nxt_st.leds.gwSys.yel = 1'b1;
         GW_BOOT: begin
            nxt_st.leds.gwSys.yel = st_ff.flashPh;
            nxt_st.leds.gwSys.grn = !st_ff.flashPh;
         end
         GW_RUN: nxt_st.leds.gwSys.grn = 1'b1;
         GW_OFF, GW_FAULT: nxt_st.leds.gwSys = '0;
         default: nxt_st.leds.gwSys = '0;
      endcase

      // Gateway communication indicator, errors first
      nxt_st.leds.gwCom = '0;
      if (link.slaveDisc) begin
         nxt_st.leds.gwCom.red = 1'b1;
      end else if (link.slaveLost) begin
         nxt_st.leds.gwCom.red = st_ff.flashPh;
      end else if (link.noConfig || link.stackErr) begin
         nxt_st.leds.gwCom.grn = irrOn;
      end else if (link.commUp) begin
         nxt_st.leds.gwCom.grn = 1'b1;
      end else if (link.configured) begin
         nxt_st.leds.gwCom.grn = st_ff.flashPh;
      end

      // Register writes
      if (wrAcc && paddr == `SLI_CTRL_OFS) begin
         nxt_st.lossless = pwdata[`SLI_CTRL_LOSSLESS];
      end
      if (wrAcc && paddr == `SLI_INT_MSK_OFS) begin
         nxt_st.intMask = pwdata[`SLI_EV_W-1:0];
      end
      // Write one to clear; a new event in the same cycle wins
      if (wrAcc && paddr == `SLI_INT_ST_OFS) begin
         nxt_st.intSt = st_ff.intSt & ~pwdata[`SLI_EV_W-1:0];
      end
      nxt_st.intSt = nxt_st.intSt | evRise;
      nxt_st.evPrev = evNow;

      // Read data captured in the setup phase
      if (psel && !penable && !pwrite) begin
         nxt_st.prdata = '0;
         unique case (paddr)
            `SLI_CTRL_OFS: nxt_st.prdata[`SLI_CTRL_LOSSLESS] = st_ff.lossless;
            `SLI_STAT_OFS: nxt_st.prdata = {11'h0, st_ff.blocked,
               st_ff.gw, $bits(sli_leds_t)'(st_ff.leds)};
            `SLI_INT_ST_OFS: nxt_st.prdata[`SLI_EV_W-1:0] = st_ff.intSt;
            `SLI_INT_MSK_OFS: nxt_st.prdata[`SLI_EV_W-1:0] = st_ff.intMask;
            default: nxt_st.prdata = '0;
         endcase
      end
   end

   // State register; reset shows the power-up red pair
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= '0;
         st_ff.gw <= GW_OFF;
         st_ff.lossless <= `SLI_CTRL_RST;
         st_ff.leds.proc.red <= 1'b1;
         st_ff.leds.dev.red <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Initialization lights both indicators red
   property p_init;
      stat.initBusy |=> leds.proc == 3'h4 && leds.dev == 3'h4;
   endproperty
   a_init: assert property (p_init) else $error("init not red");

   // Good result alone gives steady green
   property p_procOk;
      !stat.initBusy && !stat.alarm && !stat.resultNok && stat.resultOk
         |=> leds.proc == 3'h1;
   endproperty
   a_procOk: assert property (p_procOk) else $error("ok not green");

   // Steady device errors hold red for two cycles
   property p_devSteady;
      steadyErr[*2] |=> leds.dev.red && $past(leds.dev.red);
   endproperty
   a_devSteady: assert property (p_devSteady) else $error("dev err not red");

   // Channel errors follow the flash phase
   property p_devFlash;
      !stat.initBusy && !steadyErr && flashErr |=> leds.dev.red == $past(st_ff.flashPh);
   endproperty
   a_devFlash: assert property (p_devFlash) else $error("dev not flashing");

   // Fast link lights green, slow link keeps it dark
   property p_ethRate;
      link.linkUp |=> leds.eth.grn == $past(link.link100);
   endproperty
   a_ethRate: assert property (p_ethRate) else $error("eth green wrong");

   // Slow link always shows yellow unless traffic blinks it
   property p_eth10;
      link.linkUp && !link.link100 && !link.linkAct |=> leds.eth == 3'h2;
   endproperty
   a_eth10: assert property (p_eth10) else $error("eth yellow wrong");

   // Running gateway settles on steady green
   property p_gwRun;
      st_ff.gw == GW_RUN && link.gwPowerOk && link.fwRunning
         |=> leds.gwSys == 3'h1;
   endproperty
   a_gwRun: assert property (p_gwRun) else $error("gw not green");

   // Start phase lasting too long turns into a fault
   property p_gwStuck;
      st_ff.gw == GW_START && link.gwPowerOk && !link.fwRunning && !link.bootCopy
         && tick && st_ff.stuckCnt == `SLI_STUCK_TICKS |=> st_ff.gw == GW_FAULT;
   endproperty
   a_gwStuck: assert property (p_gwStuck) else $error("no stuck fault");

   // Boot copy swaps yellow and green with the flash phase
   property p_gwBoot;
      st_ff.gw == GW_BOOT && link.gwPowerOk && !link.fwRunning
         && !(tick && st_ff.stuckCnt == `SLI_STUCK_TICKS)
         |=> leds.gwSys.yel == $past(st_ff.flashPh) && leds.gwSys.grn != $past(st_ff.flashPh)
         && !leds.gwSys.red;
   endproperty
   a_gwBoot: assert property (p_gwBoot) else $error("gw boot not alternating");

   // Without supply the gateway indicator goes dark
   property p_gwOff;
      !link.gwPowerOk |=> leds.gwSys == 3'h0;
   endproperty
   a_gwOff: assert property (p_gwOff) else $error("gw not dark");

   // Disconnection is steady red over everything else
   property p_comDisc;
      link.slaveDisc |=> leds.gwCom == 3'h4;
   endproperty
   a_comDisc: assert property (p_comDisc) else $error("com not red");

   // Lost slave flashes red with green dark
   property p_comLost;
      link.slaveLost && !link.slaveDisc
         |=> leds.gwCom.red == $past(st_ff.flashPh) && !leds.gwCom.grn && !leds.gwCom.yel;
   endproperty
   a_comLost: assert property (p_comLost) else $error("com not flashing red");

   // Failed lossless store blocks finish and start next cycle
   property p_block;
      st_ff.lossless && storeFail |=> st_ff.blocked && !startAllow && !procFinished;
   endproperty
   a_block: assert property (p_block) else $error("backup not blocking");

endmodule
`default_nettype wire

// ---- testbench/sli_panel_model.sv ----
// Front panel model: operator view of the gateway system indicator
`timescale 1ns/1ps
`default_nettype none
module sli_panel_model
   import sli_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire sli_leds_t leds,
   output logic [15:0] maxYel
);
   logic [15:0] run; // Current steady yellow run, cycles
   // Longest yellow-only run, a stuck gateway start shows here
   always @(posedge clk) begin
      if (srst) begin
         run <= 16'h0000;
         maxYel <= 16'h0000;
      end else if (leds.gwSys === 3'h2) begin
         run <= run + 16'h0001;
         if (run >= maxYel) begin
            maxYel <= run + 16'h0001;
         end
      end else begin
         run <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench of the status LED indicator
`timescale 1ns/1ps
`default_nettype none
`include "sli_params.svh"
module tb_top
   import sli_pkg::*;
;
   localparam int HALF = 4; // Short flash half period
   localparam int YMAX = (`SLI_STUCK_TICKS + 2) * HALF; // Longest legal yellow
   localparam int YMIN = `SLI_STUCK_TICKS * HALF; // Shortest yellow before a fault
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   sli_stat_t stat = '0;
   sli_link_t link = '0;
   logic procDoneIn = 1'b0;
   logic storeFail = 1'b0;
   logic storeOk = 1'b0;
   logic procFinished;
   logic startAllow;
   sli_leds_t leds;
   logic irq;
   logic [15:0] maxYel;
   logic [31:0] rd; // Last read data
   logic err; // Last slave error
   int failCount = 0;
   int checked = 0;
   // Status table: {stat, dev select, steady, flashing}
   logic [23:0] sTab [16] = '{24'h4000_04, 24'h2000_02, 24'h1000_08, 24'h0800_20,
      24'h5000_04, 24'h1800_20, 24'h0400_60, 24'h0200_60, 24'h0100_60, 24'h0080_60,
      24'h0040_60, 24'h0010_44, 24'h0020_44, 24'h000c_44, 24'h0002_44, 24'h0410_60};
   // Link table: {link, com select, steady, flashing}
   logic [19:0] lTab [12] = '{20'hc00_18, 20'he00_0a, 20'h800_10, 20'ha00_02,
      20'h001_a0, 20'h002_84, 20'h020_81, 20'h010_81, 20'h008_81, 20'h004_88,
      20'h005_a0, 20'h006_84};

   always #2 clk = ~clk;

   status_led_indicator #(.FLASH_HALF_CYC(HALF)) DUT (.clk(clk), .srst(srst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .stat(stat), .link(link),
      .procDoneIn(procDoneIn), .storeFail(storeFail), .storeOk(storeOk),
      .procFinished(procFinished), .startAllow(startAllow), .leds(leds), .irq(irq));

   sli_panel_model panel (.clk(clk), .srst(srst), .leds(leds), .maxYel(maxYel));

   // Count one comparison, report a mismatch
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer; request held until pready seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Read a register and compare the masked bits
   task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] m,
         input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(nm, exp, rd & m);
   endtask

   // Apply status and link flags, let the indicators settle
   task automatic setIn(input logic [15:0] s, input logic [11:0] l);
      @(posedge clk);
      stat <= sli_stat_t'(s);
      link <= sli_link_t'(l);
      repeat (3) @(posedge clk);
   endtask

   // Watch one indicator: steady bits fixed, flashing bits seen on and off
   task automatic watch(input string nm, input int i, input logic [2:0] st,
         input logic [2:0] fm);
      logic [2:0] v;
      logic [2:0] sv;
      logic [2:0] hi;
      logic [2:0] lo;
      hi = 3'h0;
      lo = 3'h0;
      sv = 3'h0;
      // Long enough for six half periods, irregular pattern included
      for (int k = 0; k < 24; k++) begin
         @(posedge clk);
         v = leds[14 - 3 * i -: 3];
         if (k == 0) begin
            sv = v & ~fm;
         end else if ((v & ~fm) !== sv) begin
            sv = 3'bxxx;
         end
         hi |= v & fm;
         lo |= ~v & fm;
      end
      chk(nm, {26'h0, st, fm}, {26'h0, sv, hi & lo});
   endtask

   // Print counts and the verdict, then stop
   task automatic completeRun();
      $display("Comparisons %0d, mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog, far beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      failCount++;
      completeRun();
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("resetLeds", 32'h4800, {17'h0, leds});
      chk("resetIrq", 32'h0, {31'h0, irq});
      rdChk("ctrlRst", `SLI_CTRL_OFS, 32'hffffffff, 32'h0);
      rdChk("mskRst", `SLI_INT_MSK_OFS, 32'hffffffff, 32'h0);
      rdChk("unmapped", 12'h010, 32'hffffffff, 32'h0);
      chk("slvErr", 32'h1, {31'h0, err});
      setIn(16'h8000, 12'h000);
      chk("initLeds", 32'h24, {26'h0, leds[14:9]});
      chk("initStart", 32'h0, {31'h0, startAllow});
      $display("Test reset done");
      // Process and device indicators, priorities included
      foreach (sTab[j]) begin
         setIn(sTab[j][23:8], 12'h000);
         watch("statLed", sTab[j][6] ? 1 : 0, sTab[j][5:3], sTab[j][2:0]);
      end
      setIn(16'h0000, 12'h000);
      rdChk("devEvent", `SLI_INT_ST_OFS, 32'hf, 32'h2);
      chk("irqMasked", 32'h0, {31'h0, irq});
      apb(1'b1, `SLI_INT_MSK_OFS, 32'h2);
      @(posedge clk);
      chk("irqOn", 32'h1, {31'h0, irq});
      apb(1'b1, `SLI_INT_ST_OFS, 32'h2);
      @(posedge clk);
      chk("irqOff", 32'h0, {31'h0, irq});
      rdChk("intClr", `SLI_INT_ST_OFS, 32'hf, 32'h0);
      $display("Test status done");
      // Ethernet and communication indicators
      foreach (lTab[j]) begin
         setIn(16'h0000, lTab[j][19:8]);
         watch("linkLed", lTab[j][7] ? 4 : 2, lTab[j][5:3], lTab[j][2:0]);
      end
      $display("Test link done");
      // Gateway start, run, boot copy, stuck start, power loss
      setIn(16'h0000, 12'h100);
      watch("gwStart", 3, 3'h2, 3'h0);
      setIn(16'h0000, 12'h180);
      watch("gwRun", 3, 3'h1, 3'h0);
      setIn(16'h0000, 12'h140);
      watch("gwBoot", 3, 3'h0, 3'h3);
      // Back to run, then firmware stops and the start phase hangs
      setIn(16'h0000, 12'h180);
      watch("gwBack", 3, 3'h1, 3'h0);
      setIn(16'h0000, 12'h100);
      repeat (100) @(posedge clk);
      watch("gwFault", 3, 3'h0, 3'h0);
      rdChk("gwState", `SLI_STAT_OFS, 32'h000f8000, 32'h00080000);
      setIn(16'h0000, 12'h000);
      watch("gwOff", 3, 3'h0, 3'h0);
      chk("yelRun", 32'h1, {31'h0, maxYel >= YMIN && maxYel <= YMAX});
      $display("Test gateway done");
      // Failed store outside lossless mode blocks nothing
      @(posedge clk);
      procDoneIn <= 1'b1;
      storeFail <= 1'b1;
      @(posedge clk);
      storeFail <= 1'b0;
      repeat (2) @(posedge clk);
      chk("finFree", 32'h1, {31'h0, procFinished});
      apb(1'b1, `SLI_CTRL_OFS, 32'h1);
      apb(1'b1, `SLI_INT_MSK_OFS, 32'h1);
      @(posedge clk);
      storeFail <= 1'b1;
      storeOk <= 1'b1;
      @(posedge clk);
      storeFail <= 1'b0;
      storeOk <= 1'b0;
      repeat (2) @(posedge clk);
      chk("finHeld", 32'h0, {31'h0, procFinished});
      chk("startHeld", 32'h0, {31'h0, startAllow});
      chk("irqBlock", 32'h1, {31'h0, irq});
      rdChk("blocked", `SLI_STAT_OFS, 32'h00100000, 32'h00100000);
      @(posedge clk);
      storeOk <= 1'b1;
      @(posedge clk);
      storeOk <= 1'b0;
      repeat (2) @(posedge clk);
      chk("finBack", 32'h1, {31'h0, procFinished});
      chk("startBack", 32'h1, {31'h0, startAllow});
      rdChk("intAll", `SLI_INT_ST_OFS, 32'hf, 32'hd);
      $display("Test backup done");
      completeRun();
   end
endmodule
`default_nettype wire
